// [verif/sbr_host_model.sv]
/*
 SMBus host controller model driving SCL and pulling or releasing SDA.
 Assumes the bench resolves SDA with a pull-up.
*/
module sbr_host_model (
	output logic      o_scl,
	output logic      o_sda,
	input  wire logic i_sda
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam time HALF = 24;
	time slow = 0;

	// Clock stands high between frames
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	// Value 1 releases the line; slow stretches the low phase
	task automatic xfer(input logic bv, output logic r);
		o_sda = bv;
		#(HALF + slow) o_scl = 1'b1;
		r = i_sda;
		#HALF o_scl = 1'b0;
	endtask

	task automatic start;
		o_sda = 1'b1;
		#HALF o_scl = 1'b1;
		#HALF o_sda = 1'b0;
		#HALF o_scl = 1'b0;
	endtask

	task automatic stop;
		o_sda = 1'b0;
		#HALF o_scl = 1'b1;
		#HALF o_sda = 1'b1;
		#(2 * HALF);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic [7:0] ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xfer(d[i], r);
		xfer(1'b1, r);
		ack = {7'h0, !r};
	endtask

	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			xfer(1'b1, r);
			d[i] = r;
		end
		xfer(last, r);
	endtask
endmodule

// [verif/sbr_top_props.sv]
/*
 Port checker for sbr_top, bound at the foot of this file.
 Assumes clock enable is lowered only while the bus is idle.
*/
module sbr_top_props (
	input wire logic       i_ref_clk,
	input wire logic       i_rst_n,
	input wire logic       i_clk_en,
	input wire logic       i_scl_clk,
	input wire logic       o_sda,
	input wire logic       o_sda_oe,
	input wire logic       o_output18_enable,
	input wire logic       o_output17_enable,
	input wire logic       o_output16_enable,
	input wire logic [1:0] o_pll_mode,
	input wire logic       o_frequency_strap_readback
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] en_cnt_reg;
	logic [3:0] fall_cnt_reg;
	logic       scl_reg;
	wire  [2:0] en = {o_output18_enable, o_output17_enable, o_output16_enable};

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	// Enabled edges since reset, saturating
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
		if (!i_rst_n)
			en_cnt_reg <= 4'h0;
		else if (i_clk_en && en_cnt_reg != 4'hf)
			en_cnt_reg <= en_cnt_reg + 4'h1;

	// Edges since SCL fell; saturates so stale falls do not excuse a drive
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
		if (!i_rst_n)
		begin
			scl_reg      <= 1'b1;
			fall_cnt_reg <= 4'hf;
		end
		else
		begin
			scl_reg <= i_scl_clk;
			if (scl_reg && !i_scl_clk)
				fall_cnt_reg <= 4'h0;
			else if (fall_cnt_reg != 4'hf)
				fall_cnt_reg <= fall_cnt_reg + 4'h1;
		end

	sda_low_only_a: assert property (o_sda_oe |-> !o_sda)
		else $error("sda driven high");
	drive_after_fall_a: assert property ($changed(o_sda_oe) |->
		fall_cnt_reg inside {[4'h1:4'h9]}) else $error("late sda change");
	drive_scl_low_a: assert property ($changed(o_sda_oe) |->
		!i_scl_clk) else $error("sda changed while scl high");
	no_early_ack_a: assert property (en_cnt_reg < 4'h4 |-> !o_sda_oe)
		else $error("ack before straps latched");
	en_reset_a: assert property ($rose(i_rst_n) |-> en == 3'h7)
		else $error("enables not one after reset");
	en_on_ack_a: assert property (!$stable(en) |-> ##[0:6] o_sda_oe)
		else $error("enable changed outside ack");
	mode_fixed_a: assert property (en_cnt_reg > 4'h7 |-> $stable(
		{o_pll_mode, o_frequency_strap_readback})) else $error("latch moved");
	freeze_hold_a: assert property (!i_clk_en |=>
		$stable({en, o_pll_mode, o_sda_oe})) else $error("state moved frozen");
endmodule

bind sbr_top sbr_top_props chk_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_clk_en(i_clk_en), .i_scl_clk(i_scl_clk), .o_sda(o_sda),
	.o_sda_oe(o_sda_oe), .o_output18_enable(o_output18_enable),
	.o_output17_enable(o_output17_enable),
	.o_output16_enable(o_output16_enable), .o_pll_mode(o_pll_mode),
	.o_frequency_strap_readback(o_frequency_strap_readback));

// [verif/sbr_top_tb.sv]
/*
 Self-checking bench for sbr_top driven by an SMBus host model.
 Assumes the bound port checker and the host model.
*/
module sbr_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] ADDRS [9] = '{8'hd8, 8'hda, 8'hde, 8'hc2,
		8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hce};
	logic       clk, rst_n, clk_en, freq, lf, scl, sda_h, oe, sda_o;
	logic       e18, e17, e16, fo;
	logic [1:0] mode, lm, mo;
	logic [3:0] straps;
	logic [7:0] a, b, addr, cnt_exp, w;
	logic [7:0] d[$], e[$];
	int         n_mismatch, compares, cyc, n;
	int         seed = 32'h0dc4e8af;
	wire        sda = sda_h & !(oe & !sda_o);

	sbr_top dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
		.i_scl_clk(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(oe),
		.i_target_address_straps(straps), .i_pll_mode_strap(mode),
		.i_frequency_strap(freq), .o_output18_enable(e18),
		.o_output17_enable(e17), .o_output16_enable(e16),
		.o_pll_mode(mo), .o_frequency_strap_readback(fo));
	sbr_host_model host_u (.o_scl(scl), .o_sda(sda_h), .i_sda(sda));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// Strap code 3 also means high
	function automatic logic [1:0] lv(input int s, input int k);
		return (s == 2) ? {1'b1, k[0]} : 2'(s);
	endfunction

	function automatic logic [7:0] exp_byte(input int i, input logic [7:0] v);
		if (i == 0)
			return {lm, v[5:3], 2'h0, lf};
		return (i == 7) ? {3'h0, v[4:0]} : 8'h00;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic do_reset(input int k);
		@(negedge clk);
		rst_n = 1'b0;
		straps = {lv(k / 3, k), lv(k % 3, k)};
		mode = 2'($random(seed));
		freq = 1'($random(seed));
		lm = mode;
		lf = freq;
		cnt_exp = 8'h08;
		repeat (10) @(negedge clk);
		clk_en = 1'b0;
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
		chk({mo, 5'h0, fo}, 8'h00);
		clk_en = 1'b1;
		repeat (20) @(negedge clk);
		chk({e18, e17, e16, 5'h0}, 8'he0);
		chk({mo, 5'h0, fo}, {lm, 5'h0, lf});
	endtask

	task automatic bwrite(input logic [7:0] idx, input logic [7:0] q[$]);
		host_u.start();
		host_u.wbyte(addr, a);
		chk(a, 8'h01);
		host_u.wbyte(idx, a);
		chk(a, 8'h01);
		host_u.wbyte(8'(q.size()), a);
		chk(a, 8'h01);
		foreach (q[i])
		begin
			host_u.wbyte(q[i], a);
			chk(a, 8'h01);
		end
		host_u.stop();
	endtask

	task automatic bread(input logic [7:0] idx, input logic [7:0] q[$]);
		host_u.start();
		host_u.wbyte(addr, a);
		chk(a, 8'h01);
		host_u.wbyte(idx, a);
		chk(a, 8'h01);
		host_u.start();
		host_u.wbyte(addr | 8'h01, a);
		chk(a, 8'h01);
		host_u.rbyte(1'b0, b);
		chk(b, cnt_exp);
		foreach (q[i])
		begin
			host_u.rbyte(i == q.size() - 1, b);
			chk(b, q[i]);
		end
		host_u.stop();
	endtask

	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		straps = 4'h0;
		mode = 2'h0;
		freq = 1'b0;
		for (int k = 0; k < 9; k++)
		begin
			do_reset(k);
			addr = ADDRS[k];
			host_u.start();
			host_u.wbyte(ADDRS[(k + 3) % 9], a);
			chk(a, 8'h00);
			host_u.stop();
			bread(8'h00, {exp_byte(0, 8'hff)});
		end
		// Latched readback must ignore later strap moves
		@(negedge clk);
		mode = ~mode;
		freq = !freq;
		for (int j = 0; j < 5; j++)
		begin
			n = (j < 3) ? 1 : 8;
			host_u.slow = j[0] ? 40 : 0;
			d = {};
			e = {};
			for (int i = 0; i < n; i++)
			begin
				w = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'($random(seed));
				d.push_back(w);
				e.push_back(exp_byte(i, w));
			end
			bwrite(8'h00, d);
			chk({e18, e17, e16, 5'h0}, {d[0][5:3], 5'h0});
			if (n == 8)
				cnt_exp = e[7];
			bread(8'h00, e);
			if (n == 8)
				bread(8'h07, {e[7]});
		end
		tally_and_finish();
	end
endmodule

// [verilog/sbr_bit_capture.sv]
/*
 Link-side bit sampler, clocked by the SMBus clock itself.
 Each rising clock edge captures the data line and flips a toggle, which
 the reference domain synchronises. Assumes the data line is stable
 around the rising edge, as the bus timing guarantees.
*/
module sbr_bit_capture (
	input  wire logic i_scl_clk,
	input  wire logic i_rst_n,
	input  wire logic i_sda,
	output logic      o_bit,
	output logic      o_toggle
);
	// Bit stays stable a whole clock-high time, long past the crossing
	always_ff @(posedge i_scl_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_bit    <= 1'b0;
			o_toggle <= 1'b0;
		end
		else
		begin
			o_bit    <= i_sda;
			o_toggle <= ~o_toggle;
		end
	end
endmodule

// [verilog/sbr_pkg.sv]
/*
 Constants for the SMBus block register port: register indices, field
 positions, reset values, strap coding and the target address table.
 Assumes the importing logic runs on the 200 MHz reference clock.
*/
package sbr_pkg;

	// Register indices
	localparam logic [7:0] SBR_IDX_CTRL  = 8'h00;
	localparam logic [7:0] SBR_IDX_COUNT = 8'h07;

	// Byte zero layout
	localparam int SBR_MODE_MSB = 7;
	localparam int SBR_MODE_LSB = 6;
	localparam int SBR_EN18_BIT = 5;
	localparam int SBR_EN16_BIT = 3;
	localparam int SBR_FREQ_BIT = 0;
	localparam logic [2:0] SBR_EN_RESET = 3'h7;

	// Byte count register: five writable bits, msb is bit 4
	localparam int SBR_CNT_WIDTH = 5;
	localparam logic [4:0] SBR_CNT_RESET = 5'h08;

	// Three-level strap coding per strap
	localparam logic [1:0] SBR_LVL_LOW  = 2'h0;
	localparam logic [1:0] SBR_LVL_MID  = 2'h1;
	localparam logic [1:0] SBR_LVL_HIGH = 2'h2;

	// Address per strap pair, index = strap1 * 3 + strap0, write bit 0
	localparam logic [7:0] SBR_ADDR_TBL [0:8] = '{
		8'hd8, 8'hda, 8'hde,
		8'hc2, 8'hc4, 8'hc6,
		8'hca, 8'hcc, 8'hce
	};

	// Strap pipeline fill before latching
	localparam logic [1:0] SBR_STRAP_SETTLE = 2'h3;

	typedef enum logic [2:0] {
		SBR_IDLE   = 3'b000,
		SBR_ADDR   = 3'b001,
		SBR_INDEX  = 3'b010,
		SBR_COUNT  = 3'b011,
		SBR_WDATA  = 3'b100,
		SBR_RCOUNT = 3'b101,
		SBR_RDATA  = 3'b110
	} sbr_state_e;

endpackage

// [verilog/sbr_sync2.sv]
/*
 Two flip-flop synchroniser for a bus of levels.
 Assumes the inputs are levels from outside the destination clock domain.
*/
module sbr_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_clk_en,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;

	// Refused at elaboration; a zero-width bus has nothing to carry
	if (WIDTH < 1)
	begin
		$error("sbr_sync2: WIDTH must be at least 1");
	end

	// First stage feeds only the second stage
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_reg <= '0;
			o_sync   <= '0;
		end
		else if (i_clk_en)
		begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule

// [verilog/sbr_top.sv]
/*
 SMBus target with indexed block write and block read of a byte-wide
 register file: control byte zero and the readback count register.
 Assumes an open-drain bus resolved outside, the SMBus clock on its own
 port, and straps stable from power-up.
*/
module sbr_top (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_clk_en,
	input  wire logic       i_scl_clk,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe,
	input  wire logic [3:0] i_target_address_straps,
	input  wire logic [1:0] i_pll_mode_strap,
	input  wire logic       i_frequency_strap,
	output logic            o_output18_enable,
	output logic            o_output17_enable,
	output logic            o_output16_enable,
	output logic [1:0]      o_pll_mode,
	output logic            o_frequency_strap_readback
);
	import sbr_pkg::*;

	logic                     cap_bit;
	logic                     cap_toggle;
	logic [2:0]               line_sync;
	logic [6:0]               strap_sync;
	logic                     scl_s;
	logic                     sda_s;
	logic                     tgl_s;
	logic                     scl_prev_reg;
	logic                     sda_prev_reg;
	logic                     tgl_prev_reg;
	logic                     start_evt;
	logic                     stop_evt;
	logic                     rise_evt;
	logic                     fall_evt;
	logic [1:0]               settle_reg;
	logic                     latched_reg;
	logic [7:0]               my_addr_reg;
	logic [1:0]               mode_reg;
	logic                     freq_reg;
	logic [2:0]               en_reg;
	logic [SBR_CNT_WIDTH-1:0] cnt_reg;
	sbr_state_e               state_reg;
	sbr_state_e               state_next;
	logic [7:0]               shift_reg;
	logic [3:0]               bit_cnt_reg;
	logic                     in_ack_reg;
	logic                     host_ack_reg;
	logic [7:0]               ptr_reg;
	logic [7:0]               rd_byte;
	logic [3:0]               strap_idx;
	logic                     addr_hit;
	logic                     wr_evt;

	sbr_bit_capture u_capture (
		.i_scl_clk (i_scl_clk),
		.i_rst_n   (i_rst_n),
		.i_sda     (i_sda),
		.o_bit     (cap_bit),
		.o_toggle  (cap_toggle)
	);

	sbr_sync2 #(.WIDTH(3)) u_line_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.i_async   ({i_scl_clk, i_sda, cap_toggle}),
		.o_sync    (line_sync)
	);

	sbr_sync2 #(.WIDTH(7)) u_strap_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.i_async   ({i_target_address_straps, i_pll_mode_strap,
			i_frequency_strap}),
		.o_sync    (strap_sync)
	);

	assign scl_s = line_sync[2];
	assign sda_s = line_sync[1];
	assign tgl_s = line_sync[0];

	// Bus events from synchronised lines
	assign start_evt = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
	assign stop_evt  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
	assign rise_evt  = tgl_s != tgl_prev_reg;
	assign fall_evt  = scl_prev_reg && !scl_s;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			// Same as the synchroniser's reset, so no false edge follows
			scl_prev_reg <= 1'b0;
			sda_prev_reg <= 1'b0;
			tgl_prev_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
			tgl_prev_reg <= tgl_s;
		end
	end

	// Straps caught once, after the synchroniser has filled
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			settle_reg  <= 2'h0;
			latched_reg <= 1'b0;
			my_addr_reg <= 8'h00;
			mode_reg    <= 2'h0;
			freq_reg    <= 1'b0;
		end
		else if (i_clk_en && !latched_reg)
		begin
			if (settle_reg == SBR_STRAP_SETTLE)
			begin
				latched_reg <= 1'b1;
				my_addr_reg <= SBR_ADDR_TBL[strap_idx];
				mode_reg    <= strap_sync[2:1];
				freq_reg    <= strap_sync[0];
			end
			else
				settle_reg <= settle_reg + 2'h1;
		end
	end

	// Undefined level code counts as high
	function automatic logic [3:0] lvl(input logic [1:0] code);
		lvl = (code == SBR_LVL_LOW) ? 4'h0 :
			(code == SBR_LVL_MID) ? 4'h1 : 4'h2;
	endfunction

	assign strap_idx = 4'(lvl(strap_sync[6:5]) * 4'h3)
		+ lvl(strap_sync[4:3]);

	// Address match ignores the direction bit
	assign addr_hit = latched_reg && (shift_reg[7:1] == my_addr_reg[7:1]);

	// Read mux; unlisted indices read zero
	always_comb
	begin
		rd_byte = 8'h00;
		if (ptr_reg == SBR_IDX_CTRL)
		begin
			rd_byte[SBR_MODE_MSB:SBR_MODE_LSB] = mode_reg;
			rd_byte[SBR_EN18_BIT:SBR_EN16_BIT] = en_reg;
			rd_byte[SBR_FREQ_BIT]              = freq_reg;
		end
		else if (ptr_reg == SBR_IDX_COUNT)
			rd_byte[SBR_CNT_WIDTH-1:0] = cnt_reg;
	end

	// Next byte phase, taken as the ack slot closes
	always_comb
	begin
		state_next = SBR_IDLE;
		case (state_reg)
			SBR_ADDR:
				if (addr_hit)
					state_next = shift_reg[0] ? SBR_RCOUNT : SBR_INDEX;
			SBR_INDEX:
				state_next = SBR_COUNT;
			SBR_COUNT:
				state_next = SBR_WDATA;
			SBR_WDATA:
				state_next = SBR_WDATA;
			SBR_RCOUNT,
			SBR_RDATA:
				if (host_ack_reg)
					state_next = SBR_RDATA;
			default:
				state_next = SBR_IDLE;
		endcase
	end

	// Data byte lands when its ack slot opens
	assign wr_evt = fall_evt && !in_ack_reg && bit_cnt_reg == 4'h8
		&& state_reg == SBR_WDATA;

	// Byte engine
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_reg    <= SBR_IDLE;
			shift_reg    <= 8'h00;
			bit_cnt_reg  <= 4'h0;
			in_ack_reg   <= 1'b0;
			host_ack_reg <= 1'b0;
			ptr_reg      <= 8'h00;
			o_sda_oe     <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (start_evt)
			begin
				state_reg   <= SBR_ADDR;
				bit_cnt_reg <= 4'h0;
				in_ack_reg  <= 1'b0;
				o_sda_oe    <= 1'b0;
			end
			else if (stop_evt)
			begin
				state_reg <= SBR_IDLE;
				o_sda_oe  <= 1'b0;
			end
			else if (state_reg != SBR_IDLE)
			begin
				if (rise_evt)
				begin
					if (in_ack_reg)
						host_ack_reg <= !cap_bit;
					else if (bit_cnt_reg < 4'h8)
					begin
						shift_reg   <= {shift_reg[6:0], cap_bit};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
				else if (fall_evt)
				begin
					if (!in_ack_reg && bit_cnt_reg == 4'h8)
					begin
						in_ack_reg <= 1'b1;
						if (state_reg == SBR_ADDR)
							o_sda_oe <= addr_hit;
						else if (state_reg == SBR_INDEX
							|| state_reg == SBR_COUNT)
							o_sda_oe <= 1'b1;
						else if (state_reg == SBR_WDATA)
							o_sda_oe <= 1'b1;
						else
							o_sda_oe <= 1'b0;
						if (state_reg == SBR_INDEX)
							ptr_reg <= shift_reg;
						else if (state_reg == SBR_WDATA)
							ptr_reg <= ptr_reg + 8'h01;
					end
					else if (in_ack_reg)
					begin
						in_ack_reg  <= 1'b0;
						bit_cnt_reg <= 4'h0;
						state_reg   <= state_next;
						o_sda_oe    <= 1'b0;
						if (state_next == SBR_RCOUNT)
						begin
							shift_reg <= {{(8-SBR_CNT_WIDTH){1'b0}},
								cnt_reg};
							o_sda_oe  <= 1'b1; // Count byte msb is zero
						end
						else if (state_next == SBR_RDATA)
						begin
							shift_reg <= rd_byte;
							o_sda_oe  <= !rd_byte[7];
							ptr_reg   <= ptr_reg + 8'h01;
						end
					end
					else if (state_reg == SBR_RCOUNT
						|| state_reg == SBR_RDATA)
						o_sda_oe <= (bit_cnt_reg < 4'h8)
							&& !shift_reg[7];
				end
			end
		end
	end

	// Writable fields; reserved bits have no storage
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			en_reg  <= SBR_EN_RESET;
			cnt_reg <= SBR_CNT_RESET;
		end
		else if (i_clk_en && wr_evt)
		begin
			if (ptr_reg == SBR_IDX_CTRL)
				en_reg <= shift_reg[SBR_EN18_BIT:SBR_EN16_BIT];
			else if (ptr_reg == SBR_IDX_COUNT)
				cnt_reg <= shift_reg[SBR_CNT_WIDTH-1:0];
		end
	end

	// Outputs registered so pins never glitch
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_sda                      <= 1'b0;
			o_output18_enable          <= SBR_EN_RESET[2];
			o_output17_enable          <= SBR_EN_RESET[1];
			o_output16_enable          <= SBR_EN_RESET[0];
			o_pll_mode                 <= 2'h0;
			o_frequency_strap_readback <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_sda                      <= 1'b0;
			o_output18_enable          <= en_reg[2];
			o_output17_enable          <= en_reg[1];
			o_output16_enable          <= en_reg[0];
			o_pll_mode                 <= mode_reg;
			o_frequency_strap_readback <= freq_reg;
		end
	end
endmodule
